/* File: core/recirc_cfg.svh */
/*
 * Register map, field positions, reset values and timing counts of the
 * recirculation control block. Assumes a 40 MHz reference clock and a
 * 32-bit AHB-Lite register bus with word-aligned registers.
 */
`ifndef RECIRC_CFG_SVH
`define RECIRC_CFG_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_ROUTE       8'h04
`define REG_RATE        8'h08
`define REG_BLKSIZE     8'h0C
`define REG_FIRST       8'h10
`define REG_LAST        8'h14
`define REG_TOTAL       8'h18
`define REG_SOURCE      8'h1C
`define REG_STATUS      8'h20

// Control register fields
`define CTRL_ACTIVE_BIT   0
`define CTRL_LINK_EN_BIT  1
`define CTRL_STATION_BIT  2
`define CTRL_RESTART_BIT  3

// Route register fields: routing mask low byte, phase mode next byte
`define ROUTE_MASK_LSB    0
`define ROUTE_PHASE_LSB   8

// Reset values
`define RST_BLKSIZE       16'h0080
`define RST_RATE          4'h0
`define RST_TOTAL         16'h0001

// Smallest legal block of lags
`define BLK_MIN_LAGS      16'h0080

// Channel limits as address widths (16k and 256k channels)
`define SMALL_ADDR_W      14
`define FULL_ADDR_W       18

// Receiver restart hold time
`define CLK_PERIOD_NS     25
`define RX_RST_NS         1000
`define RX_RST_CYC   ((`RX_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: core/recirc_pkg.sv */
/*
 * Types shared by the recirculation control modules.
 * Assumes the constants of recirc_cfg.svh for all numbers.
 */
package recirc_pkg;

  // Receiver restart sequencer states, one-hot
  typedef enum logic [2:0] {
    RX_RUN  = 3'b001,
    RX_HOLD = 3'b010,
    RX_WAIT = 3'b100
  } rx_state_t;

  // Input source index for one internal stream
  typedef logic [2:0] src_sel_t;

endpackage : recirc_pkg

/* File: core/pin_sync3.sv */
/*
 * Three-stage synchroniser for a group of pin inputs. A change is taken
 * once the second and third stages agree. Assumes asynchronous inputs.
 */
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  // Raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  ////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [2:0] stage_reg;     // Stage 0 only feeds stage 1
      // Shift chain; stage 0 is read by stage 1 only
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          stage_reg <= 3'h0;
        end else begin
          stage_reg <= {stage_reg[1:0], pin_in[i]};
        end
      end
      // Accept a new level only once two later stages agree
      always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          level_out[i] <= 1'b0;
        end else if (stage_reg[1] == stage_reg[2]) begin
          level_out[i] <= stage_reg[2];
        end
      end
    end
  endgenerate

endmodule : pin_sync3

/* File: core/lag_pointer_gen.sv */
/*
 * Recirculation memory pointer generator. Walks the lags of each block
 * from the first to the last acquired block and alternates between the
 * two external memories. Assumes block size and block numbers are stable
 * while run is high.
 */
`include "recirc_cfg.svh"

module lag_pointer_gen #(
  parameter int ADDR_W = `FULL_ADDR_W
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  // Control
  input  wire logic              run_in,
  input  wire logic [15:0]       block_size_in,
  input  wire logic [15:0]       first_blk_in,
  input  wire logic [15:0]       last_blk_in,
  input  wire logic              small_limit_in,
  // Pointer
  output logic      [ADDR_W-1:0] addr_out,
  output logic                   bank_out,
  output logic      [15:0]       block_out
);

  logic [15:0]       lag_reg;    // Lag index within the block
  logic [ADDR_W-1:0] base_reg;   // Start address of current block
  logic [ADDR_W-1:0] raw_addr;   // Unlimited address

  ////////////////////////////////////////////////////////////////////////
  // Lag and block walk; the base grows by one block size per block
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lag_reg   <= 16'h0000;
      block_out <= 16'h0000;
      base_reg  <= '0;
    end else if (!run_in) begin
      lag_reg   <= 16'h0000;
      block_out <= first_blk_in;
      base_reg  <= '0;
    end else if (lag_reg + 16'h0001 >= block_size_in) begin
      lag_reg <= 16'h0000;
      if (block_out >= last_blk_in) begin
        block_out <= first_blk_in;
        base_reg  <= '0;
      end else begin
        block_out <= block_out + 16'h0001;
        base_reg  <= base_reg + ADDR_W'(block_size_in);
      end
    end else begin
      lag_reg <= lag_reg + 16'h0001;
    end
  end

  // Ping-pong bank select: each memory sees every other access
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bank_out <= 1'b0;
    end else begin
      bank_out <= run_in ? ~bank_out : 1'b0;
    end
  end

  assign raw_addr = base_reg + ADDR_W'(lag_reg);

  // Shared addresses force the small channel limit on every stream
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_out <= '0;
    end else if (small_limit_in) begin
      addr_out <= raw_addr & ADDR_W'((1 << `SMALL_ADDR_W) - 1);
    end else begin
      addr_out <= raw_addr;
    end
  end

endmodule : lag_pointer_gen

/* File: core/recirc_ctrl.sv */
/*
 * Recirculation stage control: AHB-Lite register file, stream routing,
 * master trigger selection, phase pairing, output rate strobe, memory
 * pointers and serial receiver enable/restart.
 * Assumes a single 40 MHz clock; trigger inputs arrive from pins.
 */
`include "recirc_cfg.svh"

module recirc_ctrl
  import recirc_pkg::*;
#(
  parameter int STREAMS = 8,
  parameter int ADDR_W  = `FULL_ADDR_W
) (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_b_in,
  // AHB-Lite slave
  input  wire logic                 hsel_in,
  input  wire logic [7:0]           haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic      [31:0]          hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  // Integration trigger per input source, from pins
  input  wire logic [STREAMS-1:0]   integration_trigger_stream_in,
  // Correlator-side stream control
  output logic      [STREAMS-1:0]   route_sel_out,
  output logic      [STREAMS-1:0]   corr_trigger_out,
  output logic      [STREAMS-1:0]   phase_serial_en_out,
  output logic      [STREAMS-1:0]   phase_full_res_out,
  output logic                      out_sample_strobe_out,
  output logic                      station_y_out,
  // Recirculation memory
  output logic      [ADDR_W-1:0]    mem_addr_out,
  output logic                      mem_bank_out,
  // Serial receivers
  output logic                      dynamic_phase_alignment_en_out,
  output logic                      board_serial_link_en_out,
  output logic                      board_serial_link_rst_out
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]        ctrl_reg;        // Active, link enable, station
  logic [7:0]        route_reg;       // Recirculation routing mask
  logic [7:0]        phase_reg;       // 1 = stream carries phase
  logic [3:0]        rate_reg;        // Output strobe divider
  logic [15:0]       blksize_reg;     // Lags per block
  logic [15:0]       first_lag_block_reg;
  logic [15:0]       last_lag_block_reg;
  logic [15:0]       lag_block_total_reg;
  logic [23:0]       source_reg;      // input_source_select, 3 bits each
  logic              restart_reg;     // Restart request pulse
  logic [7:0]        addr_reg;        // Data-phase address
  logic              wr_reg;          // Data-phase write pending
  logic [15:0]       factor;          // Recirculation factor
  logic              dynamic_mode;    // First and last blocks differ
  logic              small_limit;     // Upper streams recirculated
  logic [STREAMS-1:0] recirc_on;      // Stream really recirculated
  logic [STREAMS-1:0] trig_lvl;       // Synchronised trigger inputs
  logic              master_trig;     // Trigger of master source
  logic [STREAMS-1:0] paired;         // Phase stream has a partner
  logic [3:0]        rate_cnt_reg;    // Output strobe divider count
  logic [15:0]       rx_cnt_reg;      // Restart hold counter
  rx_state_t         rx_state_reg;
  logic [ADDR_W-1:0] ptr_addr;
  logic              ptr_bank;
  logic              addr_ok;         // Bus address phase accepted
  logic [31:0]       rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase
  assign addr_ok = hsel_in && htrans_in[1] && hready_in;

  // Latch address of an accepted write for its data phase
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_reg <= 8'h00;
      wr_reg   <= 1'b0;
    end else if (hready_in) begin
      addr_reg <= haddr_in;
      wr_reg   <= addr_ok && hwrite_in;
    end
  end

  // Zero wait states and always OKAY; the slave never stalls
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg            <= 8'h00;
      route_reg           <= 8'h00;
      phase_reg           <= 8'h00;
      rate_reg            <= `RST_RATE;
      blksize_reg         <= `RST_BLKSIZE;
      first_lag_block_reg <= 16'h0000;
      last_lag_block_reg  <= 16'h0000;
      lag_block_total_reg <= `RST_TOTAL;
      source_reg          <= 24'h000000;
    end else if (wr_reg) begin
      unique case (addr_reg)
        `REG_CTRL: begin
          ctrl_reg <= {5'h00, hwdata_in[`CTRL_STATION_BIT:0]};
        end
        `REG_ROUTE: begin
          route_reg <= hwdata_in[`ROUTE_MASK_LSB +: 8];
          phase_reg <= hwdata_in[`ROUTE_PHASE_LSB +: 8];
        end
        `REG_RATE:    rate_reg <= hwdata_in[3:0];
        `REG_BLKSIZE: begin
          // Too small a block is raised to the minimum
          blksize_reg <= (hwdata_in[15:0] < `BLK_MIN_LAGS) ?
                         `BLK_MIN_LAGS : hwdata_in[15:0];
        end
        `REG_FIRST:  first_lag_block_reg <= hwdata_in[15:0];
        `REG_LAST:   last_lag_block_reg  <= hwdata_in[15:0];
        `REG_TOTAL:  lag_block_total_reg <= hwdata_in[15:0];
        `REG_SOURCE: source_reg          <= hwdata_in[23:0];
        default: begin
          // Unmapped writes are ignored
        end
      endcase
    end
  end

  // Restart bit is write-one pulse, never stored
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_reg && (addr_reg == `REG_CTRL) &&
                     hwdata_in[`CTRL_RESTART_BIT];
    end
  end

  // Read data prepared in the address phase
  always_comb begin
    unique case (haddr_in)
      `REG_CTRL:    rd_mux = {24'h000000, ctrl_reg};
      `REG_ROUTE:   rd_mux = {16'h0000, phase_reg, route_reg};
      `REG_RATE:    rd_mux = {28'h0000000, rate_reg};
      `REG_BLKSIZE: rd_mux = {16'h0000, blksize_reg};
      `REG_FIRST:   rd_mux = {16'h0000, first_lag_block_reg};
      `REG_LAST:    rd_mux = {16'h0000, last_lag_block_reg};
      `REG_TOTAL:   rd_mux = {16'h0000, lag_block_total_reg};
      `REG_SOURCE:  rd_mux = {8'h00, source_reg};
      `REG_STATUS:  rd_mux = {paired, 6'h00, rx_state_reg, dynamic_mode,
                              small_limit, factor[12:0]};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hrdata_out <= 32'h00000000;
    end else if (addr_ok && !hwrite_in) begin
      hrdata_out <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Derived recirculation parameters
  assign factor       = last_lag_block_reg - first_lag_block_reg
                        + 16'h0001;
  assign dynamic_mode = first_lag_block_reg != last_lag_block_reg;
  // Nothing recirculates unless the active control is set
  assign recirc_on    = ctrl_reg[`CTRL_ACTIVE_BIT] ?
                        route_reg : '0;
  assign small_limit  = |recirc_on[STREAMS-1:STREAMS/2];

  pin_sync3 #(
    .WIDTH      (STREAMS)
  ) u_trig_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .pin_in     (integration_trigger_stream_in),
    .level_out  (trig_lvl)
  );

  // Master trigger comes from the source feeding stream zero
  assign master_trig = trig_lvl[source_reg[2:0]];

  // Phase pairing: same block half, same source, partner in data mode
  genvar s;
  generate
    for (s = 0; s < STREAMS; s++) begin : g_pair
      always_comb begin
        paired[s] = 1'b0;
        for (int j = 0; j < STREAMS; j++) begin
          if (phase_reg[s] && !phase_reg[j] &&
              ((j / (STREAMS/2)) == (s / (STREAMS/2))) &&
              (source_reg[3*j +: 3] == source_reg[3*s +: 3])) begin
            paired[s] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // Per-stream outputs toward the correlator chips
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      route_sel_out       <= '0;
      corr_trigger_out    <= '0;
      phase_serial_en_out <= '0;
      phase_full_res_out  <= '0;
    end else begin
      route_sel_out       <= recirc_on;
      for (int k = 0; k < STREAMS; k++) begin
        corr_trigger_out[k] <= recirc_on[k] ? master_trig :
                               trig_lvl[source_reg[3*k +: 3]];
      end
      phase_serial_en_out <= recirc_on & ~phase_reg;
      phase_full_res_out  <= recirc_on & paired;
    end
  end

  // Station selection is held as software set it
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      station_y_out <= 1'b0;
    end else begin
      station_y_out <= ctrl_reg[`CTRL_STATION_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output sample strobe: one pulse every rate_reg+1 cycles while any stream recirculates
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_cnt_reg          <= 4'h0;
      out_sample_strobe_out <= 1'b0;
    end else if (rate_cnt_reg >= rate_reg) begin
      rate_cnt_reg          <= 4'h0;
      out_sample_strobe_out <= |recirc_on;
    end else begin
      rate_cnt_reg          <= rate_cnt_reg + 4'h1;
      out_sample_strobe_out <= 1'b0;
    end
  end

  lag_pointer_gen #(
    .ADDR_W         (ADDR_W)
  ) u_ptr (
    .ref_clk_in     (ref_clk_in),
    .rst_b_in       (rst_b_in),
    .run_in         (|recirc_on),
    .block_size_in  (blksize_reg),
    .first_blk_in   (first_lag_block_reg),
    .last_blk_in    (last_lag_block_reg),
    .small_limit_in (small_limit),
    .addr_out       (ptr_addr),
    .bank_out       (ptr_bank),
    .block_out      ()
  );

  // Memory pins re-registered so top outputs come from flip-flops
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_addr_out <= '0;
      mem_bank_out <= 1'b0;
    end else begin
      mem_addr_out <= ptr_addr;
      mem_bank_out <= ptr_bank;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver restart: hold reset for a fixed time, then release
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_state_reg <= RX_RUN;
      rx_cnt_reg   <= 16'h0000;
    end else begin
      unique case (rx_state_reg)
        RX_RUN: begin
          if (restart_reg) begin
            rx_state_reg <= RX_HOLD;
            rx_cnt_reg   <= 16'(`RX_RST_CYC - 1);
          end
        end
        RX_HOLD: begin
          if (rx_cnt_reg == 16'h0000) begin
            rx_state_reg <= RX_WAIT;
          end else begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
          end
        end
        RX_WAIT: rx_state_reg <= RX_RUN;
        default: rx_state_reg <= RX_RUN;
      endcase
    end
  end

  // Enables follow the control, receivers held while restarting
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      board_serial_link_rst_out      <= 1'b1;
      board_serial_link_en_out       <= 1'b0;
      dynamic_phase_alignment_en_out <= 1'b0;
    end else begin
      board_serial_link_rst_out <= (rx_state_reg == RX_HOLD);
      board_serial_link_en_out  <= ctrl_reg[`CTRL_LINK_EN_BIT] &&
                                   (rx_state_reg == RX_RUN);
      dynamic_phase_alignment_en_out <=
        ctrl_reg[`CTRL_LINK_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_restart_req;
    restart_reg && rx_state_reg == RX_RUN;
  endsequence
  sequence s_rst_held;
    board_serial_link_rst_out [*8];
  endsequence

  property p_restart_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      s_restart_req |=> ##1 s_rst_held ##[1:60] !board_serial_link_rst_out;
  endproperty
  a_restart_hold: assert property (p_restart_hold)
    else $error("receiver reset not held then released");

  property p_link_en;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !ctrl_reg[`CTRL_LINK_EN_BIT] |=>
        !board_serial_link_en_out && !dynamic_phase_alignment_en_out;
  endproperty
  a_link_en: assert property (p_link_en)
    else $error("receiver enabled without control");

  property p_trig_master;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      recirc_on[1] |=> corr_trigger_out[1] == $past(master_trig);
  endproperty
  a_trig_master: assert property (p_trig_master)
    else $error("recirculated trigger not from master");

  property p_active;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !ctrl_reg[`CTRL_ACTIVE_BIT] |=> route_sel_out == '0;
  endproperty
  a_active: assert property (p_active)
    else $error("stream routed while inactive");

  property p_route;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      ctrl_reg[`CTRL_ACTIVE_BIT] |=> route_sel_out == $past(route_reg);
  endproperty
  a_route: assert property (p_route)
    else $error("routing does not follow mask");

  property p_blk_min;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      blksize_reg >= `BLK_MIN_LAGS;
  endproperty
  a_blk_min: assert property (p_blk_min)
    else $error("block size below minimum");

  property p_small;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      small_limit && $stable(small_limit) |=>
        mem_addr_out[ADDR_W-1:`SMALL_ADDR_W] == '0 || $rose(small_limit);
  endproperty
  a_small: assert property (p_small)
    else $error("address above small channel limit");

  property p_bank;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !ptr_bank && (|recirc_on) |=> ptr_bank;
  endproperty
  a_bank: assert property (p_bank)
    else $error("memory bank did not alternate");

  property p_factor;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
      !dynamic_mode |-> factor == 16'h0001;
  endproperty
  a_factor: assert property (p_factor)
    else $error("static factor is not one");

endmodule : recirc_ctrl

/* File: testbench/corr_array_model.sv */
/* Correlator array stand-in fed by the recirculation stage.
   Assumes registered control levels and the one-cycle strobe. */
module corr_array_model (
  // Stage outputs
  input  wire logic       clk_in,
  input  wire logic       strobe_in,
  input  wire logic [7:0] route_in,
  input  wire logic [7:0] phase_in,
  // Observed totals
  output int              strobe_count_out,
  output logic [7:0]      corr_mask_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial strobe_count_out = 0;
  // Phase streams are never correlated; their frames would be dropped
  assign corr_mask_out = route_in & ~phase_in;
  // One sample taken per strobe, all streams at the master's rate
  always @(posedge clk_in)
    if (strobe_in === 1'b1)
      strobe_count_out <= strobe_count_out + 1;
endmodule : corr_array_model

/* File: testbench/lag_recirculation_control_bench.sv */
/* Self-checking bench for the recirculation control block.
   Assumes one 40 MHz clock and a single AHB-Lite slave. */
`include "recirc_cfg.svh"
module lag_recirculation_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_b, hwrite, hready, hresp, station, dynamic_phase_alignment, len, lrst;
  logic [7:0]  haddr, trig, route, ctrig, pser, pfull, cmask;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, q;
  logic [17:0] maddr;
  logic        strobe, bank;
  int          strobes, fail_count, samples_checked, cyc, n;
  recirc_ctrl dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .integration_trigger_stream_in(trig), .route_sel_out(route),
    .corr_trigger_out(ctrig), .phase_serial_en_out(pser),
    .phase_full_res_out(pfull), .out_sample_strobe_out(strobe),
    .station_y_out(station), .mem_addr_out(maddr), .mem_bank_out(bank),
    .dynamic_phase_alignment_en_out(dynamic_phase_alignment), .board_serial_link_en_out(len),
    .board_serial_link_rst_out(lrst));
  corr_array_model partner (.clk_in(ref_clk), .strobe_in(strobe),
    .route_in(route), .phase_in(route & ~pser), .strobe_count_out(strobes),
    .corr_mask_out(cmask));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask : chk
  // One single AHB transfer, held until hready is seen high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic t_regs;
    bus(`REG_BLKSIZE, 0, 0); chk(q, 32'h80);
    chk(32'(hresp), 32'h0);
    bus(8'h24, 0, 0); chk(q, 32'h0);
    bus(`REG_BLKSIZE, 1, 32'h10); bus(`REG_BLKSIZE, 0, 0);
    chk(q, 32'h80);
  endtask : t_regs
  task automatic t_route;
    bus(`REG_ROUTE, 1, 32'h0F); bus(`REG_CTRL, 1, 0);
    repeat (3) @(posedge ref_clk);
    chk(32'(route), 32'h0);
    bus(`REG_CTRL, 1, 1); repeat (3) @(posedge ref_clk);
    chk(32'(route), 32'h0F);
    chk(32'(pser), 32'h0F);
  endtask : t_route
  task automatic t_trig;
    bus(`REG_SOURCE, 1, 3); trig <= 8'h08; repeat (8) @(posedge ref_clk);
    chk(32'(ctrig & 8'h0F), 32'h0F);
    trig <= 8'hF7; repeat (8) @(posedge ref_clk);
    chk(32'(ctrig & 8'h0F), 32'h0);
  endtask : t_trig
  task automatic t_status;
    bus(`REG_TOTAL, 1, 8);
    bus(`REG_FIRST, 1, 2); bus(`REG_LAST, 1, 5);
    bus(`REG_STATUS, 0, 0);
    chk(32'(q[14:0]), 32'h4004);
    bus(`REG_LAST, 1, 2); bus(`REG_STATUS, 0, 0);
    chk(32'(q[14:0]), 32'h1);
    bus(`REG_RATE, 1, 3); repeat (4) @(posedge ref_clk);
    n = strobes; repeat (40) @(posedge ref_clk);
    chk(32'(strobes - n), 32'd10);
  endtask : t_status
  task automatic t_link;
    bus(`REG_CTRL, 1, 7); repeat (3) @(posedge ref_clk);
    chk(32'({dynamic_phase_alignment, len, station}), 32'h7);
    bus(`REG_CTRL, 1, 32'hF); n = 0;
    repeat (10) if (lrst !== 1'b1) @(posedge ref_clk);
    while (lrst === 1'b1 && n < 100) begin
      @(posedge ref_clk); n++;
    end
    chk(32'(n), 32'd40);
    repeat (5) @(posedge ref_clk); chk(32'(len), 32'h1);
  endtask : t_link
  task automatic t_phase;
    bus(`REG_ROUTE, 1, 32'h020F);
    repeat (3) @(posedge ref_clk);
    chk(32'(pfull), 32'h02);
    chk(32'(pser), 32'h0D);
    chk(32'(cmask), 32'h0D);
    bus(`REG_STATUS, 0, 0); chk(32'(q[31:24]), 32'h02);
  endtask : t_phase
  task automatic t_small;
    bus(`REG_CTRL, 1, 0); bus(`REG_BLKSIZE, 1, 32'h2000);
    bus(`REG_FIRST, 1, 0); bus(`REG_LAST, 1, 3);
    bus(`REG_ROUTE, 1, 32'hF0); bus(`REG_CTRL, 1, 1);
    repeat (16500) @(posedge ref_clk);
    chk(32'(maddr[17:14]), 32'h0);
    q = 32'(bank); @(posedge ref_clk);
    chk(32'(bank ^ q[0]), 32'h1);
  endtask : t_small
  initial begin
    rst_b = 1'b0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; trig = 0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs(); t_route(); t_trig(); t_status(); t_phase(); t_link();
    t_small();
    tally_and_finish();
  end
endmodule : lag_recirculation_control_bench
